// ===== common/hdlc_pkg.sv
// Package: register map, field layout and reset values of the drive-limit bank
package hdlc_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_FEEDBACK = 6'h23;
    localparam logic [5:0] IDX_STEADY = 6'h24;
    localparam logic [5:0] IDX_OD_ONE = 6'h25;
    localparam logic [5:0] IDX_OD_TWO = 6'h26;
    localparam logic [5:0] IDX_TIMING = 6'h27;
    localparam logic [5:0] IDX_STATUS = 6'h28;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int GAIN_LSB = 0;
    localparam int GAIN_MSB = 1;
    localparam int MINFREQ_BIT = 7;
    localparam int RESYNC_BIT = 6;
    localparam int DTIME_LSB = 0;
    localparam int DTIME_MSB = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_FEEDBACK = 8'h36;
    localparam logic [7:0] RST_STEADY = 8'h64;
    localparam logic [7:0] RST_OD_ONE = 8'h80;
    localparam logic [7:0] RST_OD_TWO = 8'h00;
    localparam logic [7:0] RST_TIMING = 8'h10;

    // ------------------------------------------------------------------
    // Resonance floor and gain table (gain times 100)
    // ------------------------------------------------------------------
    localparam logic [7:0] FREQ_HIGH_HZ = 8'h7D;
    localparam logic [7:0] FREQ_LOW_HZ = 8'h2D;
    localparam logic [11:0] GAIN_LRA_0 = 12'h1F4;
    localparam logic [11:0] GAIN_LRA_1 = 12'h3E8;
    localparam logic [11:0] GAIN_LRA_2 = 12'h7D0;
    localparam logic [11:0] GAIN_LRA_3 = 12'hBB8;
    localparam logic [11:0] GAIN_ERM_0 = 12'h022;
    localparam logic [11:0] GAIN_ERM_1 = 12'h069;
    localparam logic [11:0] GAIN_ERM_2 = 12'h0B6;
    localparam logic [11:0] GAIN_ERM_3 = 12'h190;

endpackage

// ===== rtl/hdlc_clamp_sel.sv
// Effective output clamp selection from limits and battery state
module hdlc_clamp_sel (
    input wire logic [7:0] steady_drive_limit,
    input wire logic [7:0] overdrive_limit,
    input wire logic [7:0] overdrive_limit_low_batt_one,
    input wire logic [7:0] overdrive_limit_low_batt_two,
    input wire logic battery_threshold_one,
    input wire logic battery_threshold_two,
    input wire logic calib_or_diag,
    input wire logic overdrive_done,
    output logic [7:0] clamp
);

    logic [7:0] od_pick;

    // Battery levels replace the overdrive limit outside calibration and diagnostics, second level first
    always_comb begin
        od_pick = overdrive_limit;
        // R09: ignore battery levels
        if (calib_or_diag) begin
            od_pick = overdrive_limit;
        // R08: second level wins
        end else if (battery_threshold_two) begin
            od_pick = overdrive_limit_low_batt_two;
        // R07: first level replaces
        end else if (battery_threshold_one) begin
            od_pick = overdrive_limit_low_batt_one;
        end
    end

    // Steady limit only after overdrive, lower clamp wins
    always_comb begin
        clamp = od_pick;
        // R04: steady after overdrive
        if (overdrive_done) begin
            // R05: lower of the two
            // R06: battery clamp too
            clamp = (od_pick < steady_drive_limit) ? od_pick
                                                   : steady_drive_limit;
        end
    end

endmodule

// ===== rtl/hdlc_top.sv
// Drive-limit configuration bank with APB slave and clamp output
//
// Contract
// R01: Two-bit back-EMF gain, low bits, reset 2
// R02: Gain codes map to LRA and ERM gains
// R03: Calibration writes gain, software may overwrite
// R04: Steady limit clamps after overdrive ends
// R05: Lower overdrive limit overrides steady limit
// R06: Triggered battery clamp also takes lower
// R07: Below threshold one use level one
// R08: Below threshold two use level two
// R09: Calibration and diagnostics ignore battery levels
// R10: Bit 7 selects 125 or 45 Hz
// R11: Bit 6 selects resync method
// R12: Low five bits drive time, reset 16
// R13: Registers read back last written value
module hdlc_top #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lra_mode,
    input wire logic [7:0] overdrive_limit,
    input wire logic battery_threshold_one,
    input wire logic battery_threshold_two,
    input wire logic calib_active,
    input wire logic diag_active,
    input wire logic overdrive_done,
    input wire logic calib_gain_we,
    input wire logic [1:0] calib_gain,
    output logic [7:0] effective_clamp,
    output logic [1:0] backemf_amp_gain,
    output logic [11:0] backemf_gain_x100,
    output logic lowest_resonance_select,
    output logic [7:0] lowest_resonance_hz,
    output logic resync_method_select,
    output logic [4:0] drive_time
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] feedback;
        logic [7:0] steady;
        logic [7:0] od_one;
        logic [7:0] od_two;
        logic [7:0] timing;
        logic [7:0] clamp;
        logic [11:0] gain_x100;
        logic [7:0] freq_hz;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } hdlc_state_type;

    hdlc_state_type st_q;
    hdlc_state_type st_d;
    logic [7:0] clamp_sel;
    logic [5:0] idx;
    logic setup_phase;
    logic access_done;
    logic bus_write;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Register index is valid only for an aligned, mapped word
    function automatic logic hdlc_mapped(input logic [5:0] i,
                                         input logic [1:0] lo);
        hdlc_mapped = (lo == 2'h0) &&
                      ((i >= hdlc_pkg::IDX_FEEDBACK) &&
                       (i <= hdlc_pkg::IDX_STATUS));
    endfunction

    // Gain code to gain times 100 for the active actuator mode
    function automatic logic [11:0] hdlc_gain(input logic [1:0] code,
                                              input logic lra);
        logic [11:0] g;
        g = 12'h000;
        unique case (code)
            2'h0: g = lra ? hdlc_pkg::GAIN_LRA_0 : hdlc_pkg::GAIN_ERM_0;
            2'h1: g = lra ? hdlc_pkg::GAIN_LRA_1 : hdlc_pkg::GAIN_ERM_1;
            2'h2: g = lra ? hdlc_pkg::GAIN_LRA_2 : hdlc_pkg::GAIN_ERM_2;
            2'h3: g = lra ? hdlc_pkg::GAIN_LRA_3 : hdlc_pkg::GAIN_ERM_3;
        endcase
        return g;
    endfunction

    assign idx = paddr[7:2];
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && st_q.ready;
    assign bus_write = access_done && pwrite &&
                       hdlc_mapped(idx, paddr[1:0]) &&
                       (idx != hdlc_pkg::IDX_STATUS);

    // ------------------------------------------------------------------
    // Clamp selection
    // ------------------------------------------------------------------
    hdlc_clamp_sel u_clamp (
        .steady_drive_limit(st_q.steady),
        .overdrive_limit(overdrive_limit),
        .overdrive_limit_low_batt_one(st_q.od_one),
        .overdrive_limit_low_batt_two(st_q.od_two),
        .battery_threshold_one(battery_threshold_one),
        .battery_threshold_two(battery_threshold_two),
        .calib_or_diag(calib_active || diag_active),
        .overdrive_done(overdrive_done),
        .clamp(clamp_sel)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Bus slave answers in the cycle after setup, registers update on it
    always_comb begin
        st_d = st_q;
        st_d.ready = setup_phase;
        // R03: calibration fills gain
        if (calib_gain_we) begin
            st_d.feedback[hdlc_pkg::GAIN_MSB:hdlc_pkg::GAIN_LSB] =
                calib_gain;
        end
        // R13: software writes stored
        if (bus_write) begin
            unique case (idx)
                hdlc_pkg::IDX_FEEDBACK: st_d.feedback = pwdata[7:0];
                hdlc_pkg::IDX_STEADY: st_d.steady = pwdata[7:0];
                hdlc_pkg::IDX_OD_ONE: st_d.od_one = pwdata[7:0];
                hdlc_pkg::IDX_OD_TWO: st_d.od_two = pwdata[7:0];
                default: st_d.timing = pwdata[7:0];
            endcase
        end
        // Read data and error are prepared during setup
        st_d.slverr = 1'b0;
        if (setup_phase) begin
            st_d.rdata = 32'h0000_0000;
            st_d.slverr = !hdlc_mapped(idx, paddr[1:0]);
            // R13: read back stored
            if (!pwrite && hdlc_mapped(idx, paddr[1:0])) begin
                unique case (idx)
                    hdlc_pkg::IDX_FEEDBACK: st_d.rdata[7:0] = st_q.feedback;
                    hdlc_pkg::IDX_STEADY: st_d.rdata[7:0] = st_q.steady;
                    hdlc_pkg::IDX_OD_ONE: st_d.rdata[7:0] = st_q.od_one;
                    hdlc_pkg::IDX_OD_TWO: st_d.rdata[7:0] = st_q.od_two;
                    hdlc_pkg::IDX_TIMING: st_d.rdata[7:0] = st_q.timing;
                    default: st_d.rdata[7:0] = st_q.clamp;
                endcase
            end
        end
        st_d.clamp = clamp_sel;
        // R02: gain code to gain
        st_d.gain_x100 = hdlc_gain(
            st_q.feedback[hdlc_pkg::GAIN_MSB:hdlc_pkg::GAIN_LSB], lra_mode);
        // R10: resonance floor
        st_d.freq_hz = st_q.timing[hdlc_pkg::MINFREQ_BIT] ?
                       hdlc_pkg::FREQ_LOW_HZ : hdlc_pkg::FREQ_HIGH_HZ;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // R01: gain reset value
    // R12: drive time reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.feedback <= hdlc_pkg::RST_FEEDBACK;
            st_q.steady <= hdlc_pkg::RST_STEADY;
            st_q.od_one <= hdlc_pkg::RST_OD_ONE;
            st_q.od_two <= hdlc_pkg::RST_OD_TWO;
            st_q.timing <= hdlc_pkg::RST_TIMING;
            st_q.gain_x100 <= hdlc_pkg::GAIN_ERM_2;
            st_q.freq_hz <= hdlc_pkg::FREQ_HIGH_HZ;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata = st_q.rdata;
    assign pready = st_q.ready;
    assign pslverr = st_q.slverr; // Only ever set in the ready cycle
    assign effective_clamp = st_q.clamp;
    // R01: gain field out
    assign backemf_amp_gain =
        st_q.feedback[hdlc_pkg::GAIN_MSB:hdlc_pkg::GAIN_LSB];
    assign backemf_gain_x100 = st_q.gain_x100;
    assign lowest_resonance_select = st_q.timing[hdlc_pkg::MINFREQ_BIT];
    assign lowest_resonance_hz = st_q.freq_hz;
    // R11: resync method bit
    assign resync_method_select = st_q.timing[hdlc_pkg::RESYNC_BIT];
    // R12: drive time field
    assign drive_time = st_q.timing[hdlc_pkg::DTIME_MSB:hdlc_pkg::DTIME_LSB];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_WRITE_STEADY: assert property ( // R13
        bus_write && idx == hdlc_pkg::IDX_STEADY && !calib_gain_we
        |=> st_q.steady == $past(pwdata[7:0]))
        else $error("steady limit write lost");
    AST_READ_BACK: assert property ( // R13
        setup_phase && !pwrite && idx == hdlc_pkg::IDX_OD_ONE &&
        paddr[1:0] == 2'h0 |=> prdata == {24'h0, $past(st_q.od_one)})
        else $error("read data mismatch");
    AST_CALIB_GAIN: assert property ( // R03
        calib_gain_we && !bus_write |=> backemf_amp_gain == $past(calib_gain))
        else $error("calibration gain not stored");
    AST_GAIN_MAP: assert property ( // R02
        backemf_amp_gain == 2'h3 && lra_mode && $stable(lra_mode) &&
        $stable(backemf_amp_gain) |=> backemf_gain_x100 == 12'hBB8)
        else $error("gain map wrong");
    AST_CLAMP_MIN: assert property ( // R05
        overdrive_done && !battery_threshold_one &&
        !battery_threshold_two |=> effective_clamp <= $past(st_q.steady) &&
        effective_clamp <= $past(overdrive_limit))
        else $error("clamp above a limit");
    AST_OD_PHASE: assert property ( // R04
        !overdrive_done && (calib_active || diag_active)
        |=> effective_clamp == $past(overdrive_limit))
        else $error("overdrive phase clamp wrong");
    AST_BATT_TWO: assert property ( // R08
        !overdrive_done && battery_threshold_two && !calib_active &&
        !diag_active |=> effective_clamp == $past(st_q.od_two))
        else $error("level two not applied");
    AST_BATT_ONE: assert property ( // R07
        !overdrive_done && battery_threshold_one && !battery_threshold_two &&
        !calib_active && !diag_active |=> effective_clamp == $past(st_q.od_one))
        else $error("level one not applied");
    AST_FREQ: assert property ( // R10
        lowest_resonance_select && $stable(lowest_resonance_select)
        |-> lowest_resonance_hz == 8'h2D)
        else $error("resonance floor wrong");
    AST_READY_ONE: assert property ( // R13
        setup_phase |=> pready ##1 !pready)
        else $error("ready not one cycle");

    // Bus protocol and error checks
    AST_ERR_READY: assert property ( // R13
        pslverr |-> pready)
        else $error("error without ready");

    AST_READY_IDLE: assert property ( // R13
        !psel |=> !pready)
        else $error("ready without request");

    AST_UNMAPPED_ERR: assert property ( // R13
        setup_phase && !hdlc_mapped(idx, paddr[1:0]) |=> pslverr)
        else $error("bad address not refused");

    AST_STATUS_OK: assert property ( // R13
        setup_phase && idx == hdlc_pkg::IDX_STATUS && paddr[1:0] == 2'h0
        |=> !pslverr)
        else $error("status access refused");

    AST_RDATA_UPPER: assert property ( // R13
        pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");

    AST_ERR_NO_WRITE: assert property ( // R13
        access_done && pwrite && !hdlc_mapped(idx, paddr[1:0])
        |=> st_q.steady == $past(st_q.steady) &&
        st_q.od_one == $past(st_q.od_one) &&
        st_q.od_two == $past(st_q.od_two) &&
        st_q.timing == $past(st_q.timing))
        else $error("refused write changed a register");

    // Register effect checks
    AST_WRITE_OD_TWO: assert property ( // R13
        bus_write && idx == hdlc_pkg::IDX_OD_TWO
        |=> st_q.od_two == $past(pwdata[7:0]))
        else $error("level two limit write lost");

    AST_READ_TIMING: assert property ( // R13
        setup_phase && !pwrite && idx == hdlc_pkg::IDX_TIMING &&
        paddr[1:0] == 2'h0 |=> prdata == {24'h0, $past(st_q.timing)})
        else $error("timing read data mismatch");

    AST_WRITE_FEEDBACK: assert property ( // R03
        bus_write && idx == hdlc_pkg::IDX_FEEDBACK
        |=> backemf_amp_gain == $past(pwdata[1:0]))
        else $error("software gain write lost");

    AST_CALIB_KEEP: assert property ( // R03
        calib_gain_we && !bus_write
        |=> st_q.feedback[7:2] == $past(st_q.feedback[7:2]))
        else $error("calibration touched other fields");

    AST_GAIN_ERM: assert property ( // R02
        backemf_amp_gain == 2'h0 && !lra_mode && $stable(lra_mode) &&
        $stable(backemf_amp_gain) |=> backemf_gain_x100 == 12'h022)
        else $error("erm gain map wrong");

    AST_WRITE_TIMING: assert property ( // R11 R12
        bus_write && idx == hdlc_pkg::IDX_TIMING
        |=> drive_time == $past(pwdata[4:0]) &&
        resync_method_select == $past(pwdata[6]) &&
        lowest_resonance_select == $past(pwdata[7]))
        else $error("timing write lost");

    AST_TIMING_HOLD: assert property ( // R11 R12
        !(bus_write && idx == hdlc_pkg::IDX_TIMING)
        |=> $stable(resync_method_select) && $stable(drive_time))
        else $error("timing fields changed without write");

    AST_FREQ_HIGH: assert property ( // R10
        !lowest_resonance_select && $stable(lowest_resonance_select)
        |-> lowest_resonance_hz == 8'h7D)
        else $error("high resonance floor wrong");

    // Clamp checks
    AST_STEADY_CAP: assert property ( // R04
        overdrive_done |=> effective_clamp <= $past(st_q.steady))
        else $error("clamp above steady limit");

    AST_BATT_ONE_MIN: assert property ( // R06
        overdrive_done && battery_threshold_one && !battery_threshold_two &&
        !calib_active && !diag_active
        |=> effective_clamp <= $past(st_q.od_one) &&
        effective_clamp <= $past(st_q.steady) &&
        (effective_clamp == $past(st_q.od_one) ||
        effective_clamp == $past(st_q.steady)))
        else $error("level one clamp not the lower");

    AST_BATT_TWO_CAP: assert property ( // R08
        overdrive_done && battery_threshold_two && !calib_active &&
        !diag_active |=> effective_clamp <= $past(st_q.od_two))
        else $error("clamp above level two limit");

    AST_CAL_IGNORE: assert property ( // R09
        overdrive_done && (calib_active || diag_active)
        |=> effective_clamp <= $past(overdrive_limit) &&
        effective_clamp <= $past(st_q.steady) &&
        (effective_clamp == $past(overdrive_limit) ||
        effective_clamp == $past(st_q.steady)))
        else $error("battery level used in calibration");

    COV_WRITE: cover property (bus_write);
    COV_READ: cover property (access_done && !pwrite && !pslverr);
    COV_ERR: cover property (pready && pslverr);
    COV_BATT: cover property (battery_threshold_two && overdrive_done);
    COV_CAL_OD: cover property (calib_active && !overdrive_done);

endmodule

// ===== tb/hdlc_tb_top.sv
// Self-checking bench for the drive-limit configuration bank
module haptic_drive_limit_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, lra_mode = 1'b0;
    logic [7:0] od_lim = 8'h00;
    logic thr_one = 1'b0, thr_two = 1'b0, cal = 1'b0, diag = 1'b0;
    logic od_done = 1'b0, cal_we = 1'b0;
    logic [1:0] cal_gain = 2'h0, gain;
    logic [7:0] clamp, res_hz;
    logic [11:0] gain_x100;
    logic res_sel, resync;
    logic [4:0] dtime;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    hdlc_top #(.ADDR_W(8)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lra_mode(lra_mode),
        .overdrive_limit(od_lim), .battery_threshold_one(thr_one),
        .battery_threshold_two(thr_two), .calib_active(cal),
        .diag_active(diag), .overdrive_done(od_done),
        .calib_gain_we(cal_we), .calib_gain(cal_gain),
        .effective_clamp(clamp), .backemf_amp_gain(gain),
        .backemf_gain_x100(gain_x100), .lowest_resonance_select(res_sel),
        .lowest_resonance_hz(res_hz), .resync_method_select(resync),
        .drive_time(dtime)
    );

    // Clock and hang guard
    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // APB cycle; request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] ra(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction

    task automatic rdchk(input string nm, input logic [5:0] idx,
                         input logic [7:0] e);
        apb(1'b0, ra(idx), 32'h0);
        chk(nm, {24'h0, e}, rd);
        chk("slverr", 32'h0, {31'h0, err});
    endtask

    task automatic settle();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdchk("feedback", hdlc_pkg::IDX_FEEDBACK, 8'h36);
        rdchk("od_one", hdlc_pkg::IDX_OD_ONE, 8'h80);
        rdchk("od_two", hdlc_pkg::IDX_OD_TWO, 8'h00);
        rdchk("timing", hdlc_pkg::IDX_TIMING, 8'h10);
        chk("gain", 32'h2, {30'h0, gain});
        chk("hz", 32'd125, {24'h0, res_hz});
        chk("dtime", 32'd16, {27'h0, dtime});
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b1, 8'h91, 32'hFF);
        chk("unaligned err", 32'h1, {31'h0, err});
        rdchk("steady", hdlc_pkg::IDX_STEADY, 8'h64);
        $display("test reset done");
    endtask

    // Every gain code in both modes, with the calibration path
    task automatic t_gain();
        logic [11:0] tl [4];
        tl = '{hdlc_pkg::GAIN_ERM_0, hdlc_pkg::GAIN_ERM_1,
               hdlc_pkg::GAIN_ERM_2, hdlc_pkg::GAIN_ERM_3};
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, ra(hdlc_pkg::IDX_FEEDBACK), 32'h34 | c);
            settle();
            chk("x100 erm", {20'h0, tl[c]}, {20'h0, gain_x100});
        end
        tl = '{hdlc_pkg::GAIN_LRA_0, hdlc_pkg::GAIN_LRA_1,
               hdlc_pkg::GAIN_LRA_2, hdlc_pkg::GAIN_LRA_3};
        @(posedge pclk);
        lra_mode <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, ra(hdlc_pkg::IDX_FEEDBACK), 32'h34 | c);
            settle();
            chk("x100 lra", {20'h0, tl[c]}, {20'h0, gain_x100});
        end
        @(posedge pclk);
        cal_gain <= 2'h1;
        cal_we <= 1'b1;
        @(posedge pclk);
        cal_we <= 1'b0;
        rdchk("cal gain", hdlc_pkg::IDX_FEEDBACK, 8'h35);
        apb(1'b1, ra(hdlc_pkg::IDX_FEEDBACK), 32'h36);
        settle();
        chk("sw gain", 32'h2, {30'h0, gain});
        $display("test gain done");
    endtask

    task automatic t_timing();
        apb(1'b1, ra(hdlc_pkg::IDX_TIMING), 32'hC5);
        settle();
        chk("minfreq", 32'd45, {24'h0, res_hz});
        chk("sel", 32'h1, {31'h0, res_sel});
        chk("resync", 32'h1, {31'h0, resync});
        chk("dtime", 32'h5, {27'h0, dtime});
        apb(1'b1, ra(hdlc_pkg::IDX_TIMING), 32'h3F);
        settle();
        chk("minfreq", 32'd125, {24'h0, res_hz});
        chk("sel", 32'h0, {31'h0, res_sel});
        chk("resync", 32'h0, {31'h0, resync});
        chk("dtime", 32'h1F, {27'h0, dtime});
        rdchk("timing", hdlc_pkg::IDX_TIMING, 8'h3F);
        $display("test timing done");
    endtask

    task automatic ccase(input logic [7:0] od, input logic [4:0] f,
                         input logic [7:0] e);
        @(posedge pclk);
        od_lim <= od;
        {thr_one, thr_two, cal, diag, od_done} <= f;
        settle();
        chk("clamp", {24'h0, e}, {24'h0, clamp});
    endtask

    // Steady 0x50, level one 0x30, level two 0x10
    task automatic t_clamp();
        apb(1'b1, ra(hdlc_pkg::IDX_STEADY), 32'h50);
        apb(1'b1, ra(hdlc_pkg::IDX_OD_ONE), 32'h30);
        apb(1'b1, ra(hdlc_pkg::IDX_OD_TWO), 32'h10);
        rdchk("steady", hdlc_pkg::IDX_STEADY, 8'h50);
        ccase(8'h60, 5'b00000, 8'h60);
        ccase(8'h60, 5'b00001, 8'h50);
        ccase(8'h40, 5'b00001, 8'h40);
        ccase(8'h60, 5'b10001, 8'h30);
        ccase(8'h60, 5'b11001, 8'h10);
        ccase(8'h60, 5'b10000, 8'h30);
        ccase(8'h60, 5'b11000, 8'h10);
        ccase(8'h60, 5'b10100, 8'h60);
        ccase(8'h40, 5'b11101, 8'h40);
        ccase(8'h40, 5'b11011, 8'h40);
        rdchk("status", hdlc_pkg::IDX_STATUS, 8'h40);
        $display("test clamp done");
    endtask

    // ------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_gain();
        t_timing();
        t_clamp();
        close_out();
    end
endmodule
